// File: dv/tpcr_host_model.sv
// host model: sends command sub-packets, collects report bytes
// assumes tpcr_pkg compiled first; send is entered just after an edge
`timescale 1ns/1ns
`default_nettype none
module tpcr_host_model
(
   // clock and reset
   input  wire logic                core_clk,
   input  wire logic                srst,
   // command side
   output var tpcr_pkg::tpcr_cmd_t  cmd_out,
   input  wire logic                cmd_ready,
   // report side
   input  wire tpcr_pkg::tpcr_rpt_t rpt_in,
   output var logic                 rpt_ready
);
   import tpcr_pkg::*;
   logic [7:0] rx [256];      // received report bytes
   logic [7:0] rx_n = 8'h00;  // write pointer, wraps
   int         rx_pk = 0;     // complete reports seen
   logic       rx_b = 1'h0;   // port flag of the last byte
   bit         slow = 1'h0;   // sink stalls at random when set
   initial cmd_out = '0;
   initial rpt_ready = 1'h0;
   // ==========================================
   // sink: store bytes in arrival order
   always @(posedge core_clk)
   begin
      rpt_ready <= !srst && (!slow || $urandom_range(3) != 0);
      if (rpt_in.valid && rpt_ready)
      begin
         rx[rx_n] <= rpt_in.data;
         rx_n     <= rx_n + 8'h01;
         rx_b     <= rpt_in.port_b;
         if (rpt_in.last)
            rx_pk <= rx_pk + 1;
      end
   end
   // ==========================================
   // one command, a byte held until taken
   task automatic send(input logic [7:0] b [16], input int n);
      for (int i = 0; i < n; i++)
      begin
         cmd_out <= '{1'h1, b[i], i == n - 1};
         do @(posedge core_clk); while (cmd_ready !== 1'h1);
      end
      // released byte lane shows the inverse, never a stale byte
      cmd_out <= '{1'h0, ~cmd_out.data, 1'h0};
   endtask : send
endmodule : tpcr_host_model
`default_nettype wire

// File: dv/tpcr_responder_tb.sv
// testbench for the responder: bus, command, trigger and gating checks
// assumes the design files and the host model are compiled first
`timescale 1ns/1ns
`default_nettype none
module tpcr_responder_tb;
   import tpcr_pkg::*;
   // ==========================================
   // design connections
   logic        core_clk = 1'h0;
   logic        srst = 1'h1;
   logic        hsel = 1'h0;
   logic        hwrite = 1'h0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, cmd_ready, rpt_ready;
   logic        porta_timing, aux_start, aux_which;
   logic        pps_tick = 1'h0, event_in = 1'h0, aux_done = 1'h0;
   logic [31:0] sec_start = 32'h0, auto_req = 32'h0, auto_grant;
   logic [7:0]  aux_result = 8'h00;
   tpcr_cmd_t   cmd;
   tpcr_rpt_t   rpt;
   // bench state
   int          miscompares = 0, samples_checked = 0, cycles = 0, p0;
   logic [7:0]  b [16], s0;
   logic [31:0] rd, mask_q, bias;
   logic [63:0] ofs;
   logic [2:0]  cfg;
   tpcr_responder u_dut (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .cmd_in(cmd), .cmd_ready(cmd_ready), .rpt_out(rpt), .rpt_ready(rpt_ready),
      .sec_start(sec_start), .pps_tick(pps_tick), .event_in(event_in),
      .porta_timing(porta_timing), .auto_req(auto_req), .auto_grant(auto_grant),
      .aux_start(aux_start), .aux_which(aux_which), .aux_done(aux_done),
      .aux_result(aux_result));
   tpcr_host_model u_host (.core_clk(core_clk), .srst(srst), .cmd_out(cmd),
      .cmd_ready(cmd_ready), .rpt_in(rpt), .rpt_ready(rpt_ready));
   // ==========================================
   // clock and hang guard
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         miscompares++;
         summarize();
      end
   end
   // ==========================================
   // helpers
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk
   function automatic logic [7:0] got(input int i);
      return u_host.rx[8'(int'(s0) + i)];
   endfunction : got
   // one single transfer: address phase, then data phase
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge core_clk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'h1);
      rd = hrdata;
   endtask : ahb
   // send n bytes, then wait a bounded time for a whole report
   task automatic xfer(input int n, input bit want);
      p0 = u_host.rx_pk;
      s0 = u_host.rx_n;
      u_host.send(b, n);
      repeat (80) @(posedge core_clk) if (u_host.rx_pk != p0) break;
      chk(want, u_host.rx_pk != p0);
   endtask : xfer
   task automatic pps_chk();
      chk(16, 8'(u_host.rx_n - s0));
      chk(8'h4A, got(0));
      for (int i = 0; i < 3; i++) chk(cfg[i], got(1 + i));
      for (int i = 0; i < 8; i++) chk(ofs[63 - 8 * i -: 8], got(4 + i));
      for (int i = 0; i < 4; i++) chk(bias[31 - 8 * i -: 8], got(12 + i));
   endtask : pps_chk
   // plays the executing unit for the aux commands
   task automatic aux_run(input bit w, input logic [7:0] r);
      for (int n = 0; n < 40 && aux_start !== 1'h1; n++) @(posedge core_clk);
      chk(1'h1, aux_start);
      chk(w, aux_which);
      repeat (4) @(posedge core_clk);
      chk(p0, u_host.rx_pk);
      aux_done <= 1'h1;
      aux_result <= r;
      @(posedge core_clk);
      aux_done <= 1'h0;
   endtask : aux_run
   task automatic summarize();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize
   // ==========================================
   // main sequence
   initial
   begin
      void'($urandom(32870));
      repeat (8) @(posedge core_clk);
      srst <= 1'h0;
      repeat (2) @(posedge core_clk);
      ahb(1'h0, 8'h04, 32'h0);
      chk(32'h3, rd);
      ahb(1'h0, 8'h1C, 32'h0);
      chk(32'h0, rd);
      chk(32'h0, {31'h0, hresp});
      // timing request, prompt then stalling sink
      for (int k = 0; k < 2; k++)
      begin
         u_host.slow = 1'(k);
         sec_start <= $urandom;
         b[0] = 8'hAD;
         xfer(1, 1);
         chk(8'hAD, got(0));
         chk(sec_start, {got(1), got(2), got(3), got(4)});
         chk(5, 8'(u_host.rx_n - s0));
         chk(1, u_host.rx_b);
      end
      // every port A selector, then both triggers
      for (int s = 0; s < 4; s++)
      begin
         b[1] = 8'(s);
         xfer(2, 1);
         chk(16'hA500 | s, {got(0), got(1)});
         chk(0, u_host.rx_b);
         for (int t = 0; t < 2; t++)
         begin
            pps_tick <= (t == 0);
            event_in <= (t == 1);
            @(posedge core_clk);
            pps_tick <= 1'h0;
            event_in <= 1'h0;
            @(posedge core_clk);
            chk(s[t], porta_timing);
         end
      end
      // bad selector and bad length are dropped
      b[1] = 8'h04;
      xfer(2, 0);
      xfer(3, 0);
      ahb(1'h0, 8'h18, 32'h0);
      chk(2'h3, rd[1:0]);
      // pps query at defaults, random set, bad flag set
      b[0] = 8'h4A;
      xfer(1, 1);
      cfg = 3'h3;
      ofs = 64'h0;
      bias = 32'h0;
      pps_chk();
      cfg = 3'($urandom);
      ofs = {$urandom, $urandom};
      bias = $urandom;
      for (int i = 0; i < 3; i++) b[1 + i] = {7'h0, cfg[i]};
      for (int i = 0; i < 8; i++) b[4 + i] = ofs[63 - 8 * i -: 8];
      for (int i = 0; i < 4; i++) b[12 + i] = bias[31 - 8 * i -: 8];
      xfer(16, 1);
      pps_chk();
      b[2] = 8'h02;
      xfer(16, 0);
      ahb(1'h0, 8'h04, 32'h0);
      chk({29'h0, cfg}, rd);
      // mask set, query, readback and gating under each io option
      for (int k = 0; k < 4; k++)
      begin
         mask_q = (k == 0) ? 32'hFFFF_FFFF : $urandom;
         b[0] = 8'h4D;
         {b[1], b[2], b[3], b[4]} = mask_q;
         mask_q &= 32'hC000_093F;
         xfer(5, 1);
         chk(8'h4D, got(0));
         chk(mask_q, {got(1), got(2), got(3), got(4)});
         xfer(1, 1);
         chk(8'h4D, got(0));
         chk(mask_q, {got(1), got(2), got(3), got(4)});
         ahb(1'h0, 8'h00, 32'h0);
         chk(mask_q, rd);
         for (int r = 0; r < 4; r++)
         begin
            ahb(1'h1, 8'h14, 32'(r));
            auto_req <= (r == 0) ? 32'hFFFF_FFFF : $urandom;
            repeat (2) @(posedge core_clk);
            chk(auto_req & mask_q & {r[1], r[0], 30'h3FFF_FFFF}, auto_grant);
         end
      end
      // both aux commands answered only after execution ends
      for (int k = 0; k < 2; k++)
      begin
         b[0] = k ? 8'h4E : 8'h45;
         rd = $urandom;
         fork
            xfer(1, 1);
            aux_run(1'(k), rd[7:0]);
         join
         chk(b[0], got(0));
         chk({24'h0, rd[7:0]}, {got(1), got(2), got(3), got(4)});
      end
      summarize();
   end
endmodule : tpcr_responder_tb
`default_nettype wire

// File: rtl/tpcr_consts.svh
// constants for the timing packet config responder
// assumes it is included once per compilation unit
`ifndef TPCR_CONSTS_SVH
`define TPCR_CONSTS_SVH
// =====================================================
// register byte offsets
`define TPCR_OFS_AUTO_MASK 8'h00
`define TPCR_OFS_PPS_CFG   8'h04
`define TPCR_OFS_PPS_OFS_H 8'h08
`define TPCR_OFS_PPS_OFS_L 8'h0C
`define TPCR_OFS_BIAS_THR  8'h10
`define TPCR_OFS_IO_OPT    8'h14
`define TPCR_OFS_STATUS    8'h18
// =====================================================
// reset values and field masks
`define TPCR_MASK_VALID    32'hC000_093F
`define TPCR_PPS_CFG_RST   3'h3
`define TPCR_SEL_MAX       8'h03
// =====================================================
// sub-packet codes and lengths
`define TPCR_SUB_TIMING    8'hAD
`define TPCR_SUB_SPMASK    8'hA5
`define TPCR_SUB_PPS       8'h4A
`define TPCR_SUB_AUTOMASK  8'h4D
`define TPCR_SUB_AUX_ONE   8'h45
`define TPCR_SUB_AUX_TWO   8'h4E
`define TPCR_LEN_TIMING    5'h05
`define TPCR_LEN_SPMASK    5'h02
`define TPCR_LEN_PPS       5'h10
`define TPCR_LEN_AUTOMASK  5'h05
`define TPCR_LEN_AUX       5'h05
`define TPCR_BIT_IO30      30
`define TPCR_BIT_IO31      31
`endif

// File: rtl/tpcr_pkg.sv
// types for the timing packet config responder
// assumes nothing beyond the constants header
package tpcr_pkg;
   // =====================================================
   // controller states
   typedef enum logic [1:0] {
      TPCR_RX   = 2'b00,
      TPCR_EXEC = 2'b01,
      TPCR_AUX  = 2'b10,
      TPCR_TX   = 2'b11
   } tpcr_state_t;
   // command byte in, report byte out
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       last;
   } tpcr_cmd_t;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       last;
      logic       port_b;
   } tpcr_rpt_t;
endpackage : tpcr_pkg

// File: rtl/tpcr_responder.sv
// command interpreter: timing report config, pps settings, auto mask
// assumes deframed command bytes in, report bytes out, AHB-Lite regs
//
// Behaviour
// - empty timing config command: report on port B
// - port B report carries current second start
// - port A config: three bytes, selector 0..3; code takes two bytes
// - accepted selector answered with super-packet mask report
// - selector: off, pps, event, both
// - pps command always answered with pps report; code answers only a query or a 16-byte set with flags 0/1
// - pps report: sixteen bytes in fixed order
// - mask query or set answered with mask report
// - mask report: id, then 32-bit mask
// - zero bit blocks, one bit allows output
// - bits 0..5 gate decoded-data reports
// - bit 8 gates fix-complete timer report
// - bit 30 needs io option too
// - bit 31 needs io option too
// - first aux command answered after execution
// - second aux command answered after execution
// - aux report carries execution result
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`include "tpcr_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module tpcr_responder #(
   parameter logic [31:0] MASK_RST = 32'h0000_0000
) (
   // clock and reset
   input  wire logic               core_clk,
   input  wire logic               srst,
   // ahb-lite slave
   input  wire logic               hsel,
   input  wire logic [7:0]         haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic               hready,
   input  wire logic [31:0]        hwdata,
   output logic      [31:0]        hrdata,
   output logic                    hreadyout,
   output logic                    hresp,
   // command bytes in
   input  wire tpcr_pkg::tpcr_cmd_t cmd_in,
   output logic                    cmd_ready,
   // report bytes out
   output tpcr_pkg::tpcr_rpt_t     rpt_out,
   input  wire logic               rpt_ready,
   // timing sources
   input  wire logic [31:0]        sec_start,
   input  wire logic               pps_tick,
   input  wire logic               event_in,
   output logic                    porta_timing,
   // automatic output gating
   input  wire logic [31:0]        auto_req,
   output logic      [31:0]        auto_grant,
   // aux command execution
   output logic                    aux_start,
   output logic                    aux_which,
   input  wire logic               aux_done,
   input  wire logic [7:0]         aux_result
);
   import tpcr_pkg::*;

   // =====================================================
   // state
   tpcr_state_t  state;                 // controller state
   logic [7:0]   rx_buf [16];           // command bytes
   logic [4:0]   rx_cnt;                // bytes received, saturating
   logic         rx_ovf;                // command too long
   logic [127:0] rpt_vec;               // report bytes, msb first
   logic [4:0]   rpt_left;              // bytes still to send
   logic         rpt_portb;             // report goes to port B
   logic [31:0]  auto_mask;             // auto output mask
   logic [2:0]   pps_cfg;               // polarity, time base, driver
   logic [63:0]  pps_ofs;               // offset in seconds
   logic [31:0]  bias_thr;              // bias threshold
   logic [1:0]   io_opt;                // io enables for bits 30, 31
   logic [1:0]   porta_sel;             // port A timing selector
   logic         wr_pend;               // write data phase due
   logic [7:0]   wr_addr;               // address of that write

   // =====================================================
   // command decode, in the cycle after the last byte
   wire [7:0] code      = rx_buf[0];
   wire       len_ok    = !rx_ovf;
   wire       is_ad     = code == `TPCR_SUB_TIMING && len_ok;
   wire       ad_req    = is_ad && rx_cnt == 5'h01;
   wire       ad_cfg    = is_ad && rx_cnt == 5'h02
                          && rx_buf[1] <= `TPCR_SEL_MAX;
   wire       is_pps    = code == `TPCR_SUB_PPS && len_ok;
   wire       flags_ok  = rx_buf[1] <= 8'h01 && rx_buf[2] <= 8'h01
                          && rx_buf[3] <= 8'h01;
   wire       pps_query = is_pps && rx_cnt == 5'h01;
   wire       pps_set   = is_pps && rx_cnt == `TPCR_LEN_PPS && flags_ok;
   wire       is_am     = code == `TPCR_SUB_AUTOMASK && len_ok;
   wire       am_query  = is_am && rx_cnt == 5'h01;
   wire       am_set    = is_am && rx_cnt == `TPCR_LEN_AUTOMASK;
   wire       aux_one   = code == `TPCR_SUB_AUX_ONE && len_ok;
   wire       aux_two   = code == `TPCR_SUB_AUX_TWO && len_ok;
   wire [31:0] am_new   = {rx_buf[1], rx_buf[2], rx_buf[3], rx_buf[4]}
                          & `TPCR_MASK_VALID;
   wire [63:0] ofs_new  = {rx_buf[4], rx_buf[5], rx_buf[6], rx_buf[7],
                           rx_buf[8], rx_buf[9], rx_buf[10], rx_buf[11]};
   wire [31:0] bias_new = {rx_buf[12], rx_buf[13], rx_buf[14], rx_buf[15]};
   wire        in_exec  = state == TPCR_EXEC;

   // =====================================================
   // bus decode
   wire        bus_take = hsel && htrans[1] && hready;
   wire        bus_wr   = wr_pend;
   wire [31:0] rd_mux   =
      haddr == `TPCR_OFS_AUTO_MASK ? auto_mask :
      haddr == `TPCR_OFS_PPS_CFG   ? {29'h0, pps_cfg} :
      haddr == `TPCR_OFS_PPS_OFS_H ? pps_ofs[63:32] :
      haddr == `TPCR_OFS_PPS_OFS_L ? pps_ofs[31:0] :
      haddr == `TPCR_OFS_BIAS_THR  ? bias_thr :
      haddr == `TPCR_OFS_IO_OPT    ? {30'h0, io_opt} :
      haddr == `TPCR_OFS_STATUS    ? {16'h0, code, 5'h0, state != TPCR_RX, porta_sel} :
      32'h0;                                            // unmapped reads zero

   // effective mask: reserved bits dead, bits 30/31 need io option
   wire [31:0] mask_eff = auto_mask & `TPCR_MASK_VALID
                          & {io_opt[1], io_opt[0], 30'h3FFF_FFFF};

   // =====================================================
   // bus slave: zero wait, always okay, read data registered
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         hrdata    <= 32'h0;
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
         wr_pend   <= 1'b0;
         wr_addr   <= 8'h00;
      end
      else
      begin
         hreadyout <= 1'b1;
         wr_pend   <= bus_take && hwrite;
         wr_addr   <= haddr;
         if (bus_take && !hwrite)
            hrdata <= rd_mux;
      end
   end

   // =====================================================
   // settings: bus writes, then command sets take over
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         auto_mask <= MASK_RST & `TPCR_MASK_VALID;
         pps_cfg   <= `TPCR_PPS_CFG_RST;
         pps_ofs   <= 64'h0;
         bias_thr  <= 32'h0;
         io_opt    <= 2'h0;
         porta_sel <= 2'h0;
      end
      else
      begin
         if (bus_wr && wr_addr == `TPCR_OFS_AUTO_MASK)
            auto_mask <= hwdata & `TPCR_MASK_VALID;
         if (bus_wr && wr_addr == `TPCR_OFS_PPS_CFG)
            pps_cfg <= hwdata[2:0];
         if (bus_wr && wr_addr == `TPCR_OFS_PPS_OFS_H)
            pps_ofs[63:32] <= hwdata;
         if (bus_wr && wr_addr == `TPCR_OFS_PPS_OFS_L)
            pps_ofs[31:0] <= hwdata;
         if (bus_wr && wr_addr == `TPCR_OFS_BIAS_THR)
            bias_thr <= hwdata;
         if (bus_wr && wr_addr == `TPCR_OFS_IO_OPT)
            io_opt <= hwdata[1:0];
         if (in_exec && ad_cfg)
            porta_sel <= rx_buf[1][1:0];
         if (in_exec && am_set)
            auto_mask <= am_new;
         if (in_exec && pps_set)
         begin
            pps_cfg  <= {rx_buf[3][0], rx_buf[2][0], rx_buf[1][0]};
            pps_ofs  <= ofs_new;
            bias_thr <= bias_new;
         end
      end
   end

   // =====================================================
   // command byte capture
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rx_cnt <= 5'h0;
         rx_ovf <= 1'b0;
      end
      else if (state == TPCR_RX && cmd_ready && cmd_in.valid)
      begin
         if (rx_cnt[4])
            rx_ovf <= 1'b1;
         else
         begin
            rx_buf[rx_cnt[3:0]] <= cmd_in.data;
            rx_cnt              <= rx_cnt + 5'h01;
         end
      end
      else if (in_exec)
      begin
         rx_cnt <= 5'h0;
         rx_ovf <= 1'b0;
      end
   end

   // =====================================================
   // controller: execute, wait for aux, stream report
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         state     <= TPCR_RX;
         cmd_ready <= 1'b0;
         rpt_out   <= '0;
         rpt_vec   <= 128'h0;
         rpt_left  <= 5'h0;
         rpt_portb <= 1'b0;
         aux_start <= 1'b0;
         aux_which <= 1'b0;
      end
      else
      begin
         aux_start <= 1'b0;
         case (state)
            TPCR_RX:
            begin
               cmd_ready <= 1'b1;
               if (cmd_ready && cmd_in.valid && cmd_in.last)
               begin
                  cmd_ready <= 1'b0;
                  state     <= TPCR_EXEC;
               end
            end
            TPCR_EXEC:
            begin
               state     <= TPCR_TX;
               rpt_portb <= 1'b0;
               if (ad_req)
               begin
                  rpt_vec   <= {`TPCR_SUB_TIMING, sec_start, 88'h0};
                  rpt_left  <= `TPCR_LEN_TIMING;
                  rpt_portb <= 1'b1;
               end
               else if (ad_cfg)
               begin
                  rpt_vec  <= {`TPCR_SUB_SPMASK, 6'h0, rx_buf[1][1:0], 112'h0};
                  rpt_left <= `TPCR_LEN_SPMASK;
               end
               else if (pps_query || pps_set)
               begin
                  rpt_vec <= pps_set ?
                     {`TPCR_SUB_PPS, rx_buf[1], rx_buf[2], rx_buf[3], ofs_new, bias_new} :
                     {`TPCR_SUB_PPS, 7'h0, pps_cfg[0], 7'h0, pps_cfg[1],
                      7'h0, pps_cfg[2], pps_ofs, bias_thr};
                  rpt_left <= `TPCR_LEN_PPS;
               end
               else if (am_query || am_set)
               begin
                  rpt_vec  <= {`TPCR_SUB_AUTOMASK,
                               am_set ? am_new : auto_mask, 88'h0};
                  rpt_left <= `TPCR_LEN_AUTOMASK;
               end
               else if (aux_one || aux_two)
               begin
                  aux_start <= 1'b1;
                  aux_which <= aux_two;
                  state     <= TPCR_AUX;
               end
               else
                  state <= TPCR_RX;
            end
            TPCR_AUX:
            begin
               if (aux_done)
               begin
                  rpt_vec  <= {aux_which ? `TPCR_SUB_AUX_TWO : `TPCR_SUB_AUX_ONE,
                               24'h0, aux_result, 88'h0};
                  rpt_left <= `TPCR_LEN_AUX;
                  state    <= TPCR_TX;
               end
            end
            TPCR_TX:
            begin
               if (!rpt_out.valid || rpt_ready)
               begin
                  if (rpt_left != 5'h0)
                  begin
                     rpt_out  <= {1'b1, rpt_vec[127:120], rpt_left == 5'h01, rpt_portb};
                     rpt_vec  <= {rpt_vec[119:0], 8'h00};
                     rpt_left <= rpt_left - 5'h01;
                  end
                  else
                  begin
                     rpt_out.valid <= 1'b0;
                     state         <= TPCR_RX;
                  end
               end
            end
            default: state <= TPCR_RX;
         endcase
      end
   end

   // =====================================================
   // port A timing trigger and automatic output gating
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         porta_timing <= 1'b0;
         auto_grant   <= 32'h0;
      end
      else
      begin
         porta_timing <= (porta_sel[0] && pps_tick) || (porta_sel[1] && event_in);
         auto_grant   <= auto_req & mask_eff;
      end
   end

   // =====================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   sequence s_aux_go;
      in_exec && (aux_one || aux_two);
   endsequence
   sequence s_aux_back;
      state == TPCR_AUX && aux_done;
   endsequence

   a_portb_timing: assert property (in_exec && ad_req |=> state == TPCR_TX
      && rpt_portb && rpt_vec[127:88] == {`TPCR_SUB_TIMING, $past(sec_start)})
      else $error("port B timing report wrong");
   a_sel_accept: assert property (in_exec && ad_cfg
      |=> porta_sel == $past(rx_buf[1][1:0]) && rpt_vec[127:120] == `TPCR_SUB_SPMASK)
      else $error("selector not taken or not answered");
   a_sel_ignore: assert property (in_exec && is_ad && !ad_req && !ad_cfg
      |=> $stable(porta_sel) && state == TPCR_RX)
      else $error("bad selector not ignored");
   a_pps_answer: assert property (in_exec && (pps_query || pps_set)
      |=> rpt_left == `TPCR_LEN_PPS && rpt_vec[127:120] == `TPCR_SUB_PPS)
      else $error("pps report not built");
   a_mask_answer: assert property (in_exec && (am_query || am_set)
      |=> rpt_vec[127:88] == {`TPCR_SUB_AUTOMASK, auto_mask})
      else $error("mask report does not match mask");
   a_mask_rsvd: assert property ((auto_mask & ~`TPCR_MASK_VALID) == 32'h0)
      else $error("reserved mask bit set");
   // grant rebuilt from the stored mask, not from the gating wire
   a_grant_gate: assert property (##1
      auto_grant == ($past(auto_req) & $past(auto_mask) & `TPCR_MASK_VALID
                     & {$past(io_opt), 30'h3FFF_FFFF}))
      else $error("auto output not gated");
   a_aux_start: assert property (s_aux_go |=> aux_start && state == TPCR_AUX)
      else $error("aux command not started");
   // the unit may take any number of cycles, so key on its done pulse
   a_aux_answer: assert property (s_aux_back
      |=> state == TPCR_TX && rpt_vec[95:88] == $past(aux_result)
      && rpt_vec[127:120] == (aux_which ? `TPCR_SUB_AUX_TWO : `TPCR_SUB_AUX_ONE))
      else $error("aux report missing result");
   a_porta_sel: assert property (pps_tick && !event_in && porta_sel == 2'h2
      |=> !porta_timing)
      else $error("event-only selector fired on pps");
endmodule : tpcr_responder
`default_nettype wire
